//--- bench/isf_i2c_peer.sv
// behavioural i2c peer: nine scl pulses, the ninth an ack or nack slot
`timescale 1ns/1ns
module isf_i2c_peer (
  // control from the bench
  input wire logic go_in,
  input wire logic nack_in,
  // bus lines, pulled up when released, and the done flag
  output logic scl_out,
  output logic sda_out,
  output logic done_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    done_out = 1'b0;
  end
  always @(posedge go_in) begin
    done_out = 1'b0;
    #13;
    for (int i = 0; i < 9; i++) begin
      scl_out = 1'b0;
      sda_out = (i == 8) ? nack_in : i[0];
      #160 scl_out = 1'b1;
      #160 scl_out = 1'b0;
    end
    #160 sda_out = 1'b1;
    scl_out = 1'b1;
    done_out = 1'b1;
  end
endmodule

//--- bench/isf_status_flags_chk.sv
// port assertions for the status flag block
`timescale 1ns/1ns
module isf_status_flags_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // avalon-mm slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // shifter side and interrupt
  input wire isf_pkg::isf_evt_t evt_in,
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_write_out,
  input wire logic module_on_out,
  input wire logic irq_out
);
  logic tx_wr;
  logic ctrl_wr;
  logic [7:0] wd8;
  assign wd8 = avs_writedata_in[7:0];
  assign tx_wr = avs_write_in && !avs_waitrequest_out && !evt_in.busy &&
    avs_address_in == isf_pkg::OFS_TXBUF;
  assign ctrl_wr = avs_write_in && !avs_waitrequest_out &&
    avs_address_in == isf_pkg::OFS_CTRL;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wait_one_a: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out) else $error("no answer");
  wait_back_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  st_zero_a: assert property (avs_read_in && !avs_waitrequest_out &&
    avs_address_in == isf_pkg::OFS_STATUS |-> avs_readdata_out[31:16] ==
    16'h0000 && avs_readdata_out[13:11] == 3'h0) else $error("reserved set");
  txw_cause_a: assert property (tx_write_out |-> $past(tx_wr))
    else $error("tx write without accepted write");
  txw_data_a: assert property (tx_write_out |-> tx_byte_out == $past(wd8))
    else $error("tx byte wrong");
  txb_keep_a: assert property ($changed(tx_byte_out) |-> tx_write_out)
    else $error("tx byte changed");
  on_cause_a: assert property ($changed(module_on_out) |-> $past(ctrl_wr))
    else $error("enable changed without write");
  rdata_keep_a: assert property ($changed(avs_readdata_out) |->
    $past(avs_read_in || avs_write_in) && !avs_waitrequest_out)
    else $error("read data changed outside an access");
  cover property (tx_write_out);
  cover property (irq_out);
  cover property ($fell(module_on_out));
endmodule
bind isf_status_flags isf_status_flags_chk chk_u (.clk_in, .sys_rst_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_readdata_out, .avs_waitrequest_out, .evt_in, .tx_byte_out,
  .tx_write_out, .module_on_out, .irq_out);

//--- bench/isf_status_flags_tb.sv
// self-checking bench for the i2c status flag block
`timescale 1ns/1ns
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
  end \
end
module isf_status_flags_tb;
  localparam logic [4:0] ST = isf_pkg::OFS_STATUS;
  localparam logic [4:0] IS = isf_pkg::OFS_IRQ_STAT;
  localparam logic [4:0] IM = isf_pkg::OFS_IRQ_MASK;
  localparam logic [4:0] CT = isf_pkg::OFS_CTRL;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [11:0] ev = 12'h000;
  logic [7:0] rxb = 8'h00;
  logic go = 1'b0;
  logic nk = 1'b0;
  logic [31:0] rdata;
  logic [7:0] txb;
  logic wait_o, txw, on, irq, scl, sda, done;
  logic [63:0] q[$];
  logic [63:0] e;
  logic [31:0] d;
  logic [7:0] b1;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int txw_cnt = 0;
  int seed = 68933;
  isf_status_flags dut_u (.clk_in(clk), .sys_rst_in(rst),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_o), .scl_in(scl), .sda_in(sda),
    .evt_in(isf_pkg::isf_evt_t'(ev)), .rx_byte_in(rxb), .tx_byte_out(txb),
    .tx_write_out(txw), .module_on_out(on), .irq_out(irq));
  isf_i2c_peer peer_u (.go_in(go), .nack_in(nk), .scl_out(scl),
    .sda_out(sda), .done_out(done));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic summarize();
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] v);
    adr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wait_o !== 1'b0) @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] m,
    input logic [31:0] v);
    q.push_back({m, v});
    acc(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic frame(input logic n);
    pulse(11);
    rdc(ST, 32'h4000, 32'h4000);
    nk <= n;
    go <= 1'b1;
    @(posedge done);
    @(posedge clk);
    go <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
    if (txw === 1'b1) txw_cnt++;
    if (rd && wait_o === 1'b0) begin
      e = q.pop_front();
      `CHK(rdata & e[63:32], e[31:0])
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(ST, 32'hFFFF_FFFF, 32'h0);
    rdc(5'h1C, 32'hFFFF_FFFF, 32'h0);
    acc(1'b1, IM, 32'h1);
    acc(1'b1, CT, 32'h1);
    `CHK(on, 1'b1)
    for (int k = 0; k < 2; k++) begin
      frame(!k[0]);
      rdc(ST, 32'hC000, {16'h0, !k[0], 15'h0});
    end
    `CHK(irq, 1'b1)
    acc(1'b1, IM, 32'h0);
    @(posedge clk);
    `CHK(irq, 1'b0)
    acc(1'b1, IM, 32'h1);
    rdc(IS, 32'h3F, 32'h1);
    @(posedge clk);
    `CHK(irq, 1'b0)
    pulse(10);
    rdc(ST, 32'h400, 32'h400);
    rdc(IS, 32'h3F, 32'h2);
    acc(1'b1, CT, 32'h0);
    `CHK(on, 1'b0)
    rdc(ST, 32'h400, 32'h400);
    acc(1'b1, CT, 32'h1);
    rdc(ST, 32'h400, 32'h0);
    pulse(9);
    pulse(8);
    rdc(ST, 32'h300, 32'h300);
    pulse(4);
    rdc(ST, 32'h318, 32'h10);
    pulse(3);
    rdc(ST, 32'h18, 32'h8);
    acc(1'b1, ST, 32'h0);
    rdc(ST, 32'h18, 32'h0);
    pulse(6);
    rdc(ST, 32'h20, 32'h20);
    pulse(7);
    rdc(ST, 32'h20, 32'h0);
    d = $random(seed);
    acc(1'b1, isf_pkg::OFS_TXBUF, d);
    `CHK(txb, d[7:0])
    ev[0] <= 1'b1;
    acc(1'b1, isf_pkg::OFS_TXBUF, ~d);
    `CHK(txb, d[7:0])
    rdc(ST, 32'h80, 32'h80);
    ev[0] <= 1'b0;
    acc(1'b1, ST, 32'h0);
    rdc(ST, 32'h80, 32'h0);
    rdc(ST, 32'h1, 32'h1);
    pulse(1);
    rdc(ST, 32'h1, 32'h0);
    ev[2] <= 1'b1;
    @(posedge clk);
    rdc(ST, 32'h4, 32'h4);
    ev[2] <= 1'b0;
    @(posedge clk);
    rdc(ST, 32'h4, 32'h0);
    d = $random(seed);
    b1 = d[7:0];
    rxb <= b1;
    pulse(5);
    rdc(ST, 32'h42, 32'h2);
    rxb <= d[15:8];
    pulse(5);
    rdc(ST, 32'h42, 32'h42);
    rdc(isf_pkg::OFS_RXBUF, 32'hFF, {24'h0, b1});
    rdc(ST, 32'h42, 32'h40);
    acc(1'b1, ST, 32'h0);
    rdc(ST, 32'h40, 32'h0);
    `CHK(txw_cnt, 1)
    summarize();
  end
endmodule

//--- rtl/isf_pkg.sv
// package for the i2c status flag block: offsets, fields, event carrier
// Contract
// - At the end of the slave acknowledge slot of a master transmit, the ack result flag goes to one on a missing acknowledge and to zero on an acknowledge.
// - The transmit-active flag rises when a master transmission starts and falls when the acknowledge slot after the eight data bits ends.
// - A bus collision during a master operation sets the collision flag, which only an off-then-on cycle of the enable bit clears.
// - A general call address match sets the general call flag and a detected Stop clears it.
// - The second byte of a matching ten-bit address sets the ten-bit flag and a detected Stop clears it.
// - A transmit buffer write while busy is dropped and sets the write collision flag, which only software clears.
// - A byte moved into a still-full receive buffer sets the overflow flag, which only software clears.
// - As a slave, an own address match clears the data-or-address flag and a received data byte sets it.
// - Status bits 31 to 16 and 13 to 11 read as zero and every flag resets to zero.
package isf_pkg;

  // register byte offsets
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_TXBUF = 5'h04;
  localparam logic [4:0] OFS_RXBUF = 5'h08;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h0C;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h10;
  localparam logic [4:0] OFS_CTRL = 5'h14;

  // status bit positions
  localparam int ST_ACK = 15;
  localparam int ST_TRX = 14;
  localparam int ST_COL = 10;
  localparam int ST_GC = 9;
  localparam int ST_A10 = 8;
  localparam int ST_WCOL = 7;
  localparam int ST_OVF = 6;
  localparam int ST_DA = 5;
  localparam int ST_STOP = 4;
  localparam int ST_START = 3;
  localparam int ST_RW = 2;
  localparam int ST_RXFULL = 1;
  localparam int ST_TXFULL = 0;

  // interrupt status / mask bit positions
  localparam int IRQ_W = 6;
  localparam int IQ_TXDONE = 0;
  localparam int IQ_COL = 1;
  localparam int IQ_WCOL = 2;
  localparam int IQ_OVF = 3;
  localparam int IQ_STOP = 4;
  localparam int IQ_START = 5;

  // control bit: module enable
  localparam int CT_ON = 0;

  // eight data bits plus the acknowledge slot
  localparam logic [3:0] BITS_PER_XFER = 4'h9;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // one-cycle events and levels from the shifter and bus logic
  typedef struct packed {
    logic tx_start;
    logic collision;
    logic gc_match;
    logic a10_match;
    logic addr_match;
    logic data_rx;
    logic rx_xfer;
    logic stop_det;
    logic start_det;
    logic rw_bit;
    logic tx_load;
    logic busy;
  } isf_evt_t;

endpackage

//--- rtl/isf_status_flags.sv
// i2c status flag register with avalon-mm slave and interrupt
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns
module isf_status_flags (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // avalon-mm slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // i2c bus pins, sampled only
  input wire logic scl_in,
  input wire logic sda_in,
  // shifter side
  input wire isf_pkg::isf_evt_t evt_in,
  input wire logic [7:0] rx_byte_in,
  output logic [7:0] tx_byte_out,
  output logic tx_write_out,
  output logic module_on_out,
  // interrupt
  output logic irq_out
);

  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h00_0000, v};
  endfunction

  // all-clear interrupt event vector
  function automatic logic [isf_pkg::IRQ_W-1:0] IRQ_ZERO();
    IRQ_ZERO = isf_pkg::IRQ_RST;
  endfunction

  // bus slave state
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  // pin synchronisers and edge history
  logic scl_m_reg, scl_s_reg, scl_d_reg;
  logic sda_m_reg, sda_s_reg;
  // flags
  logic ack_reg, ack_next;
  logic trx_reg, trx_next;
  logic col_reg, col_next;
  logic gc_reg, gc_next;
  logic a10_reg, a10_next;
  logic wcol_reg, wcol_next;
  logic ovf_reg, ovf_next;
  logic da_reg, da_next;
  logic stop_reg, stop_next;
  logic start_reg, start_next;
  logic rw_reg, rw_next;
  logic rx_full_reg, rx_full_next;
  logic tx_full_reg, tx_full_next;
  // transmit slot tracking
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic ack_smp_reg, ack_smp_next;
  // buffers, control, interrupt
  logic [7:0] txbuf_reg, txbuf_next;
  logic [7:0] rxbuf_reg, rxbuf_next;
  logic txwr_reg, txwr_next;
  logic on_reg, on_next;
  logic [isf_pkg::IRQ_W-1:0] iqs_reg, iqs_next;
  logic [isf_pkg::IRQ_W-1:0] iqm_reg, iqm_next;
  logic irq_reg, irq_next;

  logic req, acc, do_wr, do_rd;
  logic scl_rise, scl_fall, slot_end;
  logic [31:0] status_word;
  logic [isf_pkg::IRQ_W-1:0] iq_evt;

  assign avs_waitrequest_out = wait_reg;
  assign avs_readdata_out = rdata_reg;
  assign tx_byte_out = txbuf_reg;
  assign tx_write_out = txwr_reg;
  assign module_on_out = on_reg;
  assign irq_out = irq_reg;

  always_comb begin
    req = avs_read_in | avs_write_in;
    // access completes at the edge where waitrequest is seen low
    acc = req & ~wait_reg;
    do_wr = acc & avs_write_in;
    do_rd = acc & avs_read_in;
    scl_rise = scl_s_reg & ~scl_d_reg;
    scl_fall = ~scl_s_reg & scl_d_reg;
    slot_end = trx_reg & scl_fall & (bit_cnt_reg == isf_pkg::BITS_PER_XFER);

    // unimplemented positions stay zero
    status_word = isf_pkg::ZERO_WORD;
    status_word[isf_pkg::ST_ACK] = ack_reg;
    status_word[isf_pkg::ST_TRX] = trx_reg;
    status_word[isf_pkg::ST_COL] = col_reg;
    status_word[isf_pkg::ST_GC] = gc_reg;
    status_word[isf_pkg::ST_A10] = a10_reg;
    status_word[isf_pkg::ST_WCOL] = wcol_reg;
    status_word[isf_pkg::ST_OVF] = ovf_reg;
    status_word[isf_pkg::ST_DA] = da_reg;
    status_word[isf_pkg::ST_STOP] = stop_reg;
    status_word[isf_pkg::ST_START] = start_reg;
    status_word[isf_pkg::ST_RW] = rw_reg;
    status_word[isf_pkg::ST_RXFULL] = rx_full_reg;
    status_word[isf_pkg::ST_TXFULL] = tx_full_reg;

    // bus handshake: one wait cycle, then the answer
    wait_next = ~(req & wait_reg);
    rdata_next = rdata_reg;
    if (req & wait_reg) begin
      if (!avs_read_in) begin
        // a write leaves zero on the read data
        rdata_next = isf_pkg::ZERO_WORD;
      end else if (avs_address_in == isf_pkg::OFS_STATUS) begin
        rdata_next = status_word;
      end else if (avs_address_in == isf_pkg::OFS_TXBUF) begin
        rdata_next = zext8(txbuf_reg);
      end else if (avs_address_in == isf_pkg::OFS_RXBUF) begin
        rdata_next = zext8(rxbuf_reg);
      end else if (avs_address_in == isf_pkg::OFS_IRQ_STAT) begin
        rdata_next = {26'h000_0000, iqs_reg};
      end else if (avs_address_in == isf_pkg::OFS_IRQ_MASK) begin
        rdata_next = {26'h000_0000, iqm_reg};
      end else if (avs_address_in == isf_pkg::OFS_CTRL) begin
        rdata_next = {31'h0000_0000, on_reg};
      end else begin
        rdata_next = isf_pkg::ZERO_WORD;
      end
    end

    ack_next = ack_reg;
    trx_next = trx_reg;
    col_next = col_reg;
    gc_next = gc_reg;
    a10_next = a10_reg;
    wcol_next = wcol_reg;
    ovf_next = ovf_reg;
    da_next = da_reg;
    stop_next = stop_reg;
    start_next = start_reg;
    rw_next = evt_in.rw_bit;
    rx_full_next = rx_full_reg;
    tx_full_next = tx_full_reg;
    bit_cnt_next = bit_cnt_reg;
    ack_smp_next = ack_smp_reg;
    txbuf_next = txbuf_reg;
    rxbuf_next = rxbuf_reg;
    txwr_next = 1'b0;
    on_next = on_reg;
    iqm_next = iqm_reg;
    iq_evt = IRQ_ZERO();

    // shifter took the buffer; a write in the same cycle refills it
    if (evt_in.tx_load) tx_full_next = 1'b0;

    // software side: clears first, hardware sets below win
    if (do_wr && avs_address_in == isf_pkg::OFS_STATUS) begin
      // write zero to clear; only these four may be cleared
      if (!avs_writedata_in[isf_pkg::ST_WCOL]) wcol_next = 1'b0;
      if (!avs_writedata_in[isf_pkg::ST_OVF]) ovf_next = 1'b0;
      if (!avs_writedata_in[isf_pkg::ST_STOP]) stop_next = 1'b0;
      if (!avs_writedata_in[isf_pkg::ST_START]) start_next = 1'b0;
    end else if (do_wr && avs_address_in == isf_pkg::OFS_TXBUF) begin
      if (evt_in.busy) begin
        wcol_next = 1'b1;
        iq_evt[isf_pkg::IQ_WCOL] = 1'b1;
      end else begin
        txbuf_next = avs_writedata_in[7:0];
        txwr_next = 1'b1;
        tx_full_next = 1'b1;
      end
    end else if (do_wr && avs_address_in == isf_pkg::OFS_IRQ_MASK) begin
      iqm_next = avs_writedata_in[isf_pkg::IRQ_W-1:0];
    end else if (do_wr && avs_address_in == isf_pkg::OFS_CTRL) begin
      on_next = avs_writedata_in[isf_pkg::CT_ON];
      // re-enabling after an off period clears the collision flag
      if (!on_reg && avs_writedata_in[isf_pkg::CT_ON]) col_next = 1'b0;
    end
    if (do_rd && avs_address_in == isf_pkg::OFS_RXBUF) rx_full_next = 1'b0;

    // hardware side
    if (evt_in.tx_start) begin
      trx_next = 1'b1;
      bit_cnt_next = isf_pkg::CNT_RST;
    end else if (trx_reg) begin
      // acknowledge level is taken on the ninth scl rise
      if (scl_rise) begin
        bit_cnt_next = bit_cnt_reg + isf_pkg::CNT_ONE;
        if (bit_cnt_reg + isf_pkg::CNT_ONE == isf_pkg::BITS_PER_XFER) begin
          ack_smp_next = sda_s_reg;
        end
      end
      // ninth scl fall closes the acknowledge slot
      if (slot_end) begin
        trx_next = 1'b0;
        ack_next = ack_smp_reg;
        iq_evt[isf_pkg::IQ_TXDONE] = 1'b1;
      end
    end
    if (evt_in.collision) begin
      col_next = 1'b1;
      iq_evt[isf_pkg::IQ_COL] = 1'b1;
    end
    if (evt_in.stop_det) begin
      gc_next = 1'b0;
      a10_next = 1'b0;
      stop_next = 1'b1;
      start_next = 1'b0;
      iq_evt[isf_pkg::IQ_STOP] = 1'b1;
    end
    if (evt_in.start_det) begin
      start_next = 1'b1;
      stop_next = 1'b0;
      iq_evt[isf_pkg::IQ_START] = 1'b1;
    end
    if (evt_in.gc_match) gc_next = 1'b1;
    if (evt_in.a10_match) a10_next = 1'b1;
    // a data byte in the same cycle as a match wins
    if (evt_in.addr_match) da_next = 1'b0;
    if (evt_in.data_rx) da_next = 1'b1;
    // overflow keeps the unread byte in the receive buffer
    if (evt_in.rx_xfer) begin
      if (rx_full_reg) begin
        ovf_next = 1'b1;
        iq_evt[isf_pkg::IQ_OVF] = 1'b1;
      end else begin
        rxbuf_next = rx_byte_in;
      end
      rx_full_next = 1'b1;
    end

    // interrupt status: read clears, a new event wins
    iqs_next = iqs_reg;
    if (do_rd && avs_address_in == isf_pkg::OFS_IRQ_STAT) begin
      iqs_next = IRQ_ZERO();
    end
    iqs_next = iqs_next | iq_evt;
    irq_next = |(iqs_next & iqm_next);
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_reg <= 1'b1;
      rdata_reg <= isf_pkg::ZERO_WORD;
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      ack_reg <= 1'b0;
      trx_reg <= 1'b0;
      col_reg <= 1'b0;
      gc_reg <= 1'b0;
      a10_reg <= 1'b0;
      wcol_reg <= 1'b0;
      ovf_reg <= 1'b0;
      da_reg <= 1'b0;
      stop_reg <= 1'b0;
      start_reg <= 1'b0;
      rw_reg <= 1'b0;
      rx_full_reg <= 1'b0;
      tx_full_reg <= 1'b0;
      bit_cnt_reg <= isf_pkg::CNT_RST;
      ack_smp_reg <= 1'b0;
      txbuf_reg <= isf_pkg::BYTE_RST;
      rxbuf_reg <= isf_pkg::BYTE_RST;
      txwr_reg <= 1'b0;
      on_reg <= 1'b0;
      iqs_reg <= isf_pkg::IRQ_RST;
      iqm_reg <= isf_pkg::IRQ_RST;
      irq_reg <= 1'b0;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      scl_m_reg <= scl_in;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= sda_in;
      sda_s_reg <= sda_m_reg;
      ack_reg <= ack_next;
      trx_reg <= trx_next;
      col_reg <= col_next;
      gc_reg <= gc_next;
      a10_reg <= a10_next;
      wcol_reg <= wcol_next;
      ovf_reg <= ovf_next;
      da_reg <= da_next;
      stop_reg <= stop_next;
      start_reg <= start_next;
      rw_reg <= rw_next;
      rx_full_reg <= rx_full_next;
      tx_full_reg <= tx_full_next;
      bit_cnt_reg <= bit_cnt_next;
      ack_smp_reg <= ack_smp_next;
      txbuf_reg <= txbuf_next;
      rxbuf_reg <= rxbuf_next;
      txwr_reg <= txwr_next;
      on_reg <= on_next;
      iqs_reg <= iqs_next;
      iqm_reg <= iqm_next;
      irq_reg <= irq_next;
    end
  end

endmodule
